// ===== clear_compare_decrement_pkg.sv
package clear_compare_decrement_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned REG_DEPTH = 128;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;

  // Destination bit encoding for complement and decrement
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // Reset values of the status bits held here, and the set and clear levels of a flag
  localparam logic ZERO_RST     = 1'b0;
  localparam logic CARRY_RST    = 1'b0;
  localparam logic TIMEOUT_RST  = 1'b1;
  localparam logic POWERDN_RST  = 1'b1;
  localparam logic FLAG_SET     = 1'b1;
  localparam logic FLAG_CLEAR   = 1'b0;

  typedef enum logic [2:0] {
    NOP_OP,
    CLEAR_ACCUMULATOR_OP,
    CLEAR_WATCHDOG_OP,
    CLEAR_REGISTER_OP,
    COMPLEMENT_REGISTER_OP,
    COMPARE_OP,
    DECREMENT_OP
  } op_type;

  function automatic logic isZero(input logic [DATA_W-1:0] value);
    return value == ZERO_BYTE;
  endfunction

endpackage

// ===== exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
module exec_unit (
  // Operation
  input  wire clear_compare_decrement_pkg::op_type        opCode,
  input  wire logic                                       destBit,
  // Operands
  input  wire logic [clear_compare_decrement_pkg::DATA_W-1:0] regValue,
  input  wire logic [clear_compare_decrement_pkg::DATA_W-1:0] accValue,
  // Results
  output logic [clear_compare_decrement_pkg::DATA_W-1:0]  result,
  output logic                                            writeAcc,
  output logic                                            writeReg,
  output logic                                            zeroUpdate,
  output logic                                            zeroValue,
  output logic                                            carryUpdate,
  output logic                                            carryValue,
  output logic                                            watchdogClear
);
  import clear_compare_decrement_pkg::*;

  logic [DATA_W:0] difference;

  always_comb begin
    result        = ZERO_BYTE;
    writeAcc      = 1'b0;
    writeReg      = 1'b0;
    zeroUpdate    = 1'b0;
    zeroValue     = FLAG_CLEAR;
    carryUpdate   = 1'b0;
    carryValue    = FLAG_CLEAR;
    watchdogClear = 1'b0;
    // Borrow shows in the ninth bit; carry is its inverse
    difference    = {1'b0, regValue} - {1'b0, accValue};
    unique case (opCode)
      NOP_OP: begin
      end
      CLEAR_ACCUMULATOR_OP: begin
        result     = ZERO_BYTE;
        writeAcc   = 1'b1;
        zeroUpdate = 1'b1;
        zeroValue  = FLAG_SET;
      end
      CLEAR_WATCHDOG_OP: begin
        watchdogClear = 1'b1;
      end
      CLEAR_REGISTER_OP: begin
        result     = ZERO_BYTE;
        writeReg   = 1'b1;
        zeroUpdate = 1'b1;
        zeroValue  = FLAG_SET;
      end
      COMPLEMENT_REGISTER_OP: begin
        result     = ~regValue;
        writeAcc   = (destBit == DEST_ACC);
        writeReg   = (destBit == DEST_REG);
        zeroUpdate = 1'b1;
        zeroValue  = isZero(result);
      end
      COMPARE_OP: begin
        result      = difference[DATA_W-1:0];
        zeroUpdate  = 1'b1;
        zeroValue   = isZero(difference[DATA_W-1:0]);
        carryUpdate = 1'b1;
        carryValue  = ~difference[DATA_W];
      end
      DECREMENT_OP: begin
        result     = regValue - ONE_BYTE;
        writeAcc   = (destBit == DEST_ACC);
        writeReg   = (destBit == DEST_REG);
        zeroUpdate = 1'b1;
        zeroValue  = isZero(result);
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== clear_compare_decrement_exec.sv
`timescale 1ns/1ps
`default_nettype none
module clear_compare_decrement_exec (
  // Clock and reset
  input  wire logic                                           clk,
  input  wire logic                                           sys_rst,
  // Instruction issue
  input  wire logic                                           opValid,
  input  wire clear_compare_decrement_pkg::op_type            opCode,
  input  wire logic [clear_compare_decrement_pkg::ADDR_W-1:0] regAddr,
  input  wire logic                                           destBit,
  input  wire logic                                           prescalerToWatchdog,
  // Register file observation port
  input  wire logic [clear_compare_decrement_pkg::ADDR_W-1:0] peekAddr,
  output logic [clear_compare_decrement_pkg::DATA_W-1:0]      peekData_q,
  // Core state
  output logic [clear_compare_decrement_pkg::DATA_W-1:0]      accumulator_q,
  output logic                                                zeroFlag_q,
  output logic                                                carryFlag_q,
  output logic                                                timeoutFlagN_q,
  output logic                                                powerdownFlagN_q,
  // Watchdog side
  output logic                                                watchdogClear_q,
  output logic                                                prescalerClear_q,
  // Sequencing
  output logic                                                opDone_q,
  output logic                                                skipNext_q
);
  import clear_compare_decrement_pkg::*;

  // Register file kept here so every operand read and write-back is local
  logic [DATA_W-1:0] regFile_q [REG_DEPTH];

  op_type            activeOp;
  logic [DATA_W-1:0] operandValue;
  logic [DATA_W-1:0] result;
  logic              writeAcc;
  logic              writeReg;
  logic              zeroUpdate;
  logic              zeroValue;
  logic              carryUpdate;
  logic              carryValue;
  logic              watchdogHit;

  logic [DATA_W-1:0] accumulator_d;
  logic              zeroFlag_d;
  logic              carryFlag_d;
  logic              timeoutFlagN_d;
  logic              powerdownFlagN_d;
  logic              watchdogClear_d;
  logic              prescalerClear_d;
  logic              opDone_d;
  logic              skipNext_d;
  logic [DATA_W-1:0] peekData_d;
  logic              regWrite;

  // An idle slot is executed as a no-op so nothing is touched
  assign activeOp     = opValid ? opCode : NOP_OP;
  assign operandValue = regFile_q[regAddr];

  exec_unit u_exec (
    .opCode        (activeOp),
    .destBit       (destBit),
    .regValue      (operandValue),
    .accValue      (accumulator_q),
    .result        (result),
    .writeAcc      (writeAcc),
    .writeReg      (writeReg),
    .zeroUpdate    (zeroUpdate),
    .zeroValue     (zeroValue),
    .carryUpdate   (carryUpdate),
    .carryValue    (carryValue),
    .watchdogClear (watchdogHit)
  );

  always_comb begin
    accumulator_d    = writeAcc ? result : accumulator_q;
    regWrite         = writeReg;
    zeroFlag_d       = zeroUpdate ? zeroValue : zeroFlag_q;
    carryFlag_d      = carryUpdate ? carryValue : carryFlag_q;
    timeoutFlagN_d   = watchdogHit ? FLAG_SET : timeoutFlagN_q;
    powerdownFlagN_d = watchdogHit ? FLAG_SET : powerdownFlagN_q;
    watchdogClear_d  = watchdogHit;
    prescalerClear_d = watchdogHit && prescalerToWatchdog;
    opDone_d         = opValid;
    // This block never discards the following instruction
    skipNext_d       = FLAG_CLEAR;
    peekData_d       = regFile_q[peekAddr];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accumulator_q    <= ZERO_BYTE;
      zeroFlag_q       <= ZERO_RST;
      carryFlag_q      <= CARRY_RST;
      timeoutFlagN_q   <= TIMEOUT_RST;
      powerdownFlagN_q <= POWERDN_RST;
      watchdogClear_q  <= FLAG_CLEAR;
      prescalerClear_q <= FLAG_CLEAR;
      opDone_q         <= FLAG_CLEAR;
      skipNext_q       <= FLAG_CLEAR;
      peekData_q       <= ZERO_BYTE;
    end else begin
      accumulator_q    <= accumulator_d;
      zeroFlag_q       <= zeroFlag_d;
      carryFlag_q      <= carryFlag_d;
      timeoutFlagN_q   <= timeoutFlagN_d;
      powerdownFlagN_q <= powerdownFlagN_d;
      watchdogClear_q  <= watchdogClear_d;
      prescalerClear_q <= prescalerClear_d;
      opDone_q         <= opDone_d;
      skipNext_q       <= skipNext_d;
      peekData_q       <= peekData_d;
    end
  end

  // Memory is not reset; software clears what it uses, as on any core
  always_ff @(posedge clk) begin
    if (!sys_rst && regWrite) begin
      regFile_q[regAddr] <= result;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_issue(op_type o);
    opValid && opCode == o;
  endsequence

  sequence s_issueDest(op_type o, logic d);
    opValid && opCode == o && destBit == d;
  endsequence

  property p_clear_acc;
    s_issue(CLEAR_ACCUMULATOR_OP) |=> accumulator_q == ZERO_BYTE && zeroFlag_q;
  endproperty
  a_clear_acc: assert property (p_clear_acc)
    else $error("accumulator clear did not give zero with zero flag set");

  property p_wdt_clear;
    s_issue(CLEAR_WATCHDOG_OP) |=>
      watchdogClear_q && prescalerClear_q == $past(prescalerToWatchdog) ##1 !watchdogClear_q
      or (watchdogClear_q && prescalerClear_q == $past(prescalerToWatchdog)
          && opValid && opCode == CLEAR_WATCHDOG_OP);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog or prescaler clear pulse wrong");

  property p_wdt_flags;
    s_issue(CLEAR_WATCHDOG_OP) |=> timeoutFlagN_q && powerdownFlagN_q
      && accumulator_q == $past(accumulator_q) && zeroFlag_q == $past(zeroFlag_q)
      && carryFlag_q == $past(carryFlag_q);
  endproperty
  a_wdt_flags: assert property (p_wdt_flags)
    else $error("watchdog clear left status bits wrong");

  property p_clear_reg;
    s_issue(CLEAR_REGISTER_OP) |=> regFile_q[$past(regAddr)] == ZERO_BYTE && zeroFlag_q;
  endproperty
  a_clear_reg: assert property (p_clear_reg)
    else $error("register clear did not zero the register");

  property p_complement;
    s_issueDest(COMPLEMENT_REGISTER_OP, DEST_ACC) |=>
      accumulator_q == ~$past(operandValue) && zeroFlag_q == isZero(accumulator_q);
  endproperty
  a_complement: assert property (p_complement)
    else $error("complement to accumulator wrong");

  property p_dest_reg;
    s_issueDest(DECREMENT_OP, DEST_REG) |=>
      regFile_q[$past(regAddr)] == $past(operandValue) - ONE_BYTE
      && accumulator_q == $past(accumulator_q);
  endproperty
  a_dest_reg: assert property (p_dest_reg)
    else $error("decrement write-back to register wrong");

  property p_decrement;
    s_issueDest(DECREMENT_OP, DEST_ACC) |=>
      accumulator_q == $past(operandValue) - ONE_BYTE
      && carryFlag_q == $past(carryFlag_q) && zeroFlag_q == isZero(accumulator_q);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("decrement to accumulator or flags wrong");

  property p_compare_flags;
    s_issue(COMPARE_OP) |=>
      carryFlag_q == ($past(operandValue) >= $past(accumulator_q))
      && zeroFlag_q == ($past(operandValue) == $past(accumulator_q));
  endproperty
  a_compare_flags: assert property (p_compare_flags)
    else $error("compare flags wrong");

  property p_compare_keep;
    s_issue(COMPARE_OP) |=> accumulator_q == $past(accumulator_q)
      && regFile_q[$past(regAddr)] == $past(operandValue);
  endproperty
  a_compare_keep: assert property (p_compare_keep)
    else $error("compare modified an operand");

  property p_one_cycle;
    opValid |=> opDone_q && !skipNext_q;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("instruction did not complete in one cycle without skip");

endmodule
`default_nettype wire

// ===== clear_compare_decrement_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module clear_compare_decrement_exec_test;
  import clear_compare_decrement_pkg::*;

  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       opValid = 1'b0;
  op_type     opCode = NOP_OP;
  logic [6:0] regAddr = 7'h00;
  logic       destBit = 1'b0;
  logic       prescalerToWatchdog = 1'b0;
  logic [6:0] peekAddr = 7'h00;
  logic [7:0] peekData_q;
  logic [7:0] accumulator_q;
  logic       zeroFlag_q;
  logic       carryFlag_q;
  logic       timeoutFlagN_q;
  logic       powerdownFlagN_q;
  logic       watchdogClear_q;
  logic       prescalerClear_q;
  logic       opDone_q;
  logic       skipNext_q;
  int         errTotal = 0;
  int         totalChecks = 0;

  always #25 clk = ~clk;

  clear_compare_decrement_exec dut (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .opValid          (opValid),
    .opCode           (opCode),
    .regAddr          (regAddr),
    .destBit          (destBit),
    .prescalerToWatchdog(prescalerToWatchdog),
    .peekAddr         (peekAddr),
    .peekData_q       (peekData_q),
    .accumulator_q    (accumulator_q),
    .zeroFlag_q       (zeroFlag_q),
    .carryFlag_q      (carryFlag_q),
    .timeoutFlagN_q   (timeoutFlagN_q),
    .powerdownFlagN_q (powerdownFlagN_q),
    .watchdogClear_q  (watchdogClear_q),
    .prescalerClear_q (prescalerClear_q),
    .opDone_q         (opDone_q),
    .skipNext_q       (skipNext_q)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Zero then carry, packed so one compare covers both
  task automatic flags(input logic z, input logic c);
    chk({6'h00, zeroFlag_q, carryFlag_q}, {6'h00, z, c});
  endtask

  // Issued on a falling edge; ops stay back to back until peek drops opValid
  task automatic op(input op_type c, input logic [6:0] a, input logic d, input logic p);
    opValid = 1'b1;
    opCode = c;
    regAddr = a;
    destBit = d;
    prescalerToWatchdog = p;
    @(negedge clk);
    chk({6'h00, opDone_q, skipNext_q}, 8'h02);
  endtask

  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    opValid = 1'b0;
    peekAddr = a;
    @(negedge clk);
    chk(peekData_q, exp);
  endtask

  task automatic finishTest;
    $display("checks=%0d errors=%0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic reset_values;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk(accumulator_q, 8'h00);
    flags(1'b0, 1'b0);
    chk({4'h0, timeoutFlagN_q, powerdownFlagN_q, watchdogClear_q, prescalerClear_q}, 8'h0C);
  endtask

  task automatic clear_and_step;
    op(CLEAR_REGISTER_OP, 7'h05, 1'b1, 1'b0);
    flags(1'b1, 1'b0);
    op(CLEAR_REGISTER_OP, 7'h7F, 1'b0, 1'b0);
    chk(accumulator_q, 8'h00);
    peek(7'h05, 8'h00);
    peek(7'h7F, 8'h00);
    op(DECREMENT_OP, 7'h05, 1'b1, 1'b0);
    flags(1'b0, 1'b0);
    op(DECREMENT_OP, 7'h05, 1'b1, 1'b0);
    chk(accumulator_q, 8'h00);
    peek(7'h05, 8'hFE);
    op(COMPLEMENT_REGISTER_OP, 7'h05, 1'b1, 1'b0);
    flags(1'b0, 1'b0);
    peek(7'h05, 8'h01);
    op(COMPLEMENT_REGISTER_OP, 7'h05, 1'b0, 1'b0);
    chk(accumulator_q, 8'hFE);
    peek(7'h05, 8'h01);
  endtask

  task automatic compare_cases;
    op(CLEAR_ACCUMULATOR_OP, 7'h05, 1'b1, 1'b0);
    chk(accumulator_q, 8'h00);
    flags(1'b1, 1'b0);
    op(COMPARE_OP, 7'h05, 1'b0, 1'b0);
    flags(1'b0, 1'b1);
    op(COMPARE_OP, 7'h7F, 1'b0, 1'b0);
    flags(1'b1, 1'b1);
    op(DECREMENT_OP, 7'h05, 1'b0, 1'b0);
    chk(accumulator_q, 8'h00);
    flags(1'b1, 1'b1);
    op(COMPLEMENT_REGISTER_OP, 7'h05, 1'b0, 1'b0);
    op(COMPARE_OP, 7'h05, 1'b1, 1'b0);
    flags(1'b0, 1'b0);
    chk(accumulator_q, 8'hFE);
    peek(7'h05, 8'h01);
  endtask

  task automatic watchdog_cases;
    op(CLEAR_WATCHDOG_OP, 7'h05, 1'b1, 1'b1);
    chk({4'h0, timeoutFlagN_q, powerdownFlagN_q, watchdogClear_q, prescalerClear_q}, 8'h0F);
    flags(1'b0, 1'b0);
    chk(accumulator_q, 8'hFE);
    op(CLEAR_WATCHDOG_OP, 7'h05, 1'b1, 1'b0);
    chk({4'h0, timeoutFlagN_q, powerdownFlagN_q, watchdogClear_q, prescalerClear_q}, 8'h0E);
    opCode = CLEAR_ACCUMULATOR_OP;
    peek(7'h05, 8'h01);
    chk({6'h00, watchdogClear_q, prescalerClear_q}, 8'h00);
    chk(accumulator_q, 8'hFE);
    // An issued no-op must complete yet leave every piece of state alone
    op(NOP_OP, 7'h05, 1'b0, 1'b1);
    chk(accumulator_q, 8'hFE);
    flags(1'b0, 1'b0);
    chk({4'h0, timeoutFlagN_q, powerdownFlagN_q, watchdogClear_q, prescalerClear_q}, 8'h0C);
  endtask

  // Whole sequence needs well under 100 cycles; 20 us leaves ample margin
  initial begin
    #20000;
    errTotal++;
    finishTest;
  end

  initial begin
    reset_values;
    clear_and_step;
    compare_cases;
    watchdog_cases;
    finishTest;
  end
endmodule
`default_nettype wire
